// *** ipct_pkg.sv ***
// Notes on behaviour
// - overflow interrupt requests level zero with vector D0h.
// - match/capture interrupt requests level zero with its own vector CEh.
// - overflow pending bit 0 clears when serviced, or by software writing zero.
// - with mask bit 0 set, service clears request and pending bit 1.
// - interval mode: counter equal to reference gives match, interrupt, counter clear.
// - interval mode: output pin toggles on every match.
// - pwm mode: match does not clear; counter wraps FFh to 00h.
// - pwm output low while reference <= counter, high while reference > counter.
// - pwm period is 256 ticks of the selected clock.
// - capture mode: selected edge of capture input loads counter into data register.
// - port one control low bit 4 picks capture source; 0 selects capture pin.
// - capture mode raises overflow on wrap and match/capture on each load.
// - control bits 7:5 select /1024,/256,/64,/8,/1, ext fall, ext rise, stop.
// - writing 1 to control bit 2 clears counter; bit self-clears.
// - control bit 1 enables match/capture irq, bit 0 enables overflow irq.
// - reset clears control to 00h: interval, /1024, interrupts off.
`default_nettype none
package ipct_pkg;
    // ==========================================================
    // control register layout
    localparam logic [7:0] IPCT_CTRL_RST   = 8'h00;
    localparam int         IPCT_CLK_HI     = 7;
    localparam int         IPCT_CLK_LO     = 5;
    localparam int         IPCT_MODE_HI    = 4;
    localparam int         IPCT_MODE_LO    = 3;
    localparam int         IPCT_CLR_BIT    = 2;
    localparam int         IPCT_MCIE_BIT   = 1;
    localparam int         IPCT_OVIE_BIT   = 0;
    localparam int         IPCT_CAPSEL_BIT = 4;
    localparam int         IPCT_OVF_PND    = 0;
    localparam int         IPCT_MC_PND     = 1;
    localparam int         IPCT_MASK_BIT   = 0;
    // ==========================================================
    // modes and clock selections
    localparam logic [1:0] IPCT_MODE_INTV  = 2'h0;
    localparam logic [1:0] IPCT_MODE_CAPR  = 2'h1;
    localparam logic [1:0] IPCT_MODE_CAPF  = 2'h2;
    localparam logic [1:0] IPCT_MODE_PWM   = 2'h3;
    localparam logic [2:0] IPCT_CS_1024    = 3'h0;
    localparam logic [2:0] IPCT_CS_256     = 3'h1;
    localparam logic [2:0] IPCT_CS_64      = 3'h2;
    localparam logic [2:0] IPCT_CS_8       = 3'h3;
    localparam logic [2:0] IPCT_CS_1       = 3'h4;
    localparam logic [2:0] IPCT_CS_EXTF    = 3'h5;
    localparam logic [2:0] IPCT_CS_EXTR    = 3'h6;
    localparam logic [2:0] IPCT_CS_STOP    = 3'h7;
    localparam logic [9:0] IPCT_DIV1024_M  = 10'h3FF;
    localparam logic [9:0] IPCT_DIV256_M   = 10'h0FF;
    localparam logic [9:0] IPCT_DIV64_M    = 10'h03F;
    localparam logic [9:0] IPCT_DIV8_M     = 10'h007;
    localparam logic [7:0] IPCT_CNT_MAX    = 8'hFF;
    localparam logic [7:0] IPCT_CNT_ZERO   = 8'h00;
    // ==========================================================
    // interrupt vectors on request level zero
    localparam logic [7:0] IPCT_VEC_OVF    = 8'hD0;
    localparam logic [7:0] IPCT_VEC_MC     = 8'hCE;
    typedef struct packed {
        logic       valid;
        logic [7:0] vector;
    } ipct_irq_t;
endpackage
`default_nettype wire

// *** ipct_timer.sv ***
`default_nettype none
module ipct_timer
    import ipct_pkg::*;
(
    // clock and reset
    input  wire logic       sys_clk_i,
    input  wire logic       sys_rst_i,
    // control and reference register write ports, port one control and interrupt mask inputs
    input  wire logic       ctrl_we_i,
    input  wire logic [7:0] ctrl_wdata_i,
    input  wire logic       ref_we_i,
    input  wire logic [7:0] ref_wdata_i,
    input  wire logic [7:0] port_one_control_low_i,
    input  wire logic       interrupt_mask_reg_i,
    // pending register software clear (write zero to bit)
    input  wire logic       pend_we_i,
    input  wire logic [1:0] pend_wdata_i,
    // interrupt service acknowledge
    input  wire logic       irq_ack_i,
    input  wire logic [7:0] irq_ack_vector_i,
    // pins
    input  wire logic       external_clock_pin_i,
    input  wire logic       capture_input_pin_i,
    output logic            pwm_output_pin_o,
    // status
    output logic [7:0]      timer_control_reg_o,
    output logic [7:0]      reference_data_reg_o,
    output logic [7:0]      counter_o,
    output logic [1:0]      interrupt_pending_reg_o,
    output logic            request_level_zero_o,
    output ipct_irq_t       irq_o
);
    // ==========================================================
    // pin synchronisers
    logic [1:0] ext_sync_reg;
    logic [1:0] cap_sync_reg;
    logic       ext_prev_reg;
    logic       cap_prev_reg;
    always_ff @(posedge sys_clk_i)
    begin
        if (sys_rst_i)
        begin
            ext_sync_reg <= 2'h0;
            cap_sync_reg <= 2'h0;
            ext_prev_reg <= 1'b0;
            cap_prev_reg <= 1'b0;
        end
        else
        begin
            ext_sync_reg <= {ext_sync_reg[0], external_clock_pin_i};
            cap_sync_reg <= {cap_sync_reg[0], capture_input_pin_i};
            ext_prev_reg <= ext_sync_reg[1];
            cap_prev_reg <= cap_sync_reg[1];
        end
    end
    wire ext_rise = ext_sync_reg[1] & ~ext_prev_reg;
    wire ext_fall = ~ext_sync_reg[1] & ext_prev_reg;
    // capture source other than the pin is not modelled, so it never fires
    wire cap_src_pin = ~port_one_control_low_i[IPCT_CAPSEL_BIT];
    wire cap_rise = cap_src_pin & cap_sync_reg[1] & ~cap_prev_reg;
    wire cap_fall = cap_src_pin & ~cap_sync_reg[1] & cap_prev_reg;
    // ==========================================================
    // prescaler and tick select
    logic [7:0] ctrl_reg;
    logic [9:0] pre_reg;
    wire  [2:0] clk_sel = ctrl_reg[IPCT_CLK_HI:IPCT_CLK_LO];
    wire  [1:0] mode    = ctrl_reg[IPCT_MODE_HI:IPCT_MODE_LO];
    wire tick = (clk_sel == IPCT_CS_1024) ? ((pre_reg & IPCT_DIV1024_M) == IPCT_DIV1024_M) :
                (clk_sel == IPCT_CS_256)  ? ((pre_reg & IPCT_DIV256_M) == IPCT_DIV256_M) :
                (clk_sel == IPCT_CS_64)   ? ((pre_reg & IPCT_DIV64_M) == IPCT_DIV64_M) :
                (clk_sel == IPCT_CS_8)    ? ((pre_reg & IPCT_DIV8_M) == IPCT_DIV8_M) :
                (clk_sel == IPCT_CS_1)    ? 1'b1 :
                (clk_sel == IPCT_CS_EXTF) ? ext_fall :
                (clk_sel == IPCT_CS_EXTR) ? ext_rise : 1'b0;
    // ==========================================================
    // counter and mode logic
    logic [7:0] cnt_reg;
    logic [7:0] ref_reg;
    logic       out_reg;
    logic [1:0] pend_reg;
    wire        clr_req = ctrl_we_i & ctrl_wdata_i[IPCT_CLR_BIT];
    wire is_intv = (mode == IPCT_MODE_INTV);
    wire is_pwm  = (mode == IPCT_MODE_PWM);
    wire is_cap  = (mode == IPCT_MODE_CAPR) | (mode == IPCT_MODE_CAPF);
    wire match   = tick & is_intv & (cnt_reg == ref_reg);
    wire ovf     = tick & ~is_intv & (cnt_reg == IPCT_CNT_MAX);
    wire capture = ((mode == IPCT_MODE_CAPR) & cap_rise) |
                   ((mode == IPCT_MODE_CAPF) & cap_fall);
    wire [7:0] cnt_next = (clr_req | match) ? IPCT_CNT_ZERO :
                          tick ? cnt_reg + 8'h01 : cnt_reg;
    wire [7:0] ctrl_next = {ctrl_wdata_i[IPCT_CLK_HI:IPCT_CLR_BIT + 1], 1'b0,
                            ctrl_wdata_i[IPCT_CLR_BIT - 1:0]};
    wire [7:0] ref_next = capture ? cnt_reg : (ref_we_i ? ref_wdata_i : ref_reg);
    wire pwm_next = (ref_next > cnt_next);
    wire out_next = is_pwm ? pwm_next : (match ? ~out_reg : out_reg);
    // ==========================================================
    // pending bits: set wins over clear
    wire ack_ovf = irq_ack_i & (irq_ack_vector_i == IPCT_VEC_OVF);
    wire ack_mc  = irq_ack_i & (irq_ack_vector_i == IPCT_VEC_MC) & interrupt_mask_reg_i;
    wire set_ovf = ovf & ctrl_reg[IPCT_OVIE_BIT];
    wire set_mc  = (match | (capture & is_cap)) & ctrl_reg[IPCT_MCIE_BIT];
    wire clr_ovf = ack_ovf | (pend_we_i & ~pend_wdata_i[IPCT_OVF_PND]);
    wire clr_mc  = ack_mc | (pend_we_i & ~pend_wdata_i[IPCT_MC_PND]);
    wire [1:0] pend_next = {set_mc | (pend_reg[IPCT_MC_PND] & ~clr_mc),
                            set_ovf | (pend_reg[IPCT_OVF_PND] & ~clr_ovf)};
    // overflow served first when both pend; same level, distinct vectors
    wire       req_next = |pend_next;
    wire [7:0] vec_next = pend_next[IPCT_OVF_PND] ? IPCT_VEC_OVF : IPCT_VEC_MC;
    always_ff @(posedge sys_clk_i)
    begin
        if (sys_rst_i)
        begin
            ctrl_reg <= IPCT_CTRL_RST;
            pre_reg  <= 10'h000;
            cnt_reg  <= IPCT_CNT_ZERO;
            ref_reg  <= IPCT_CNT_ZERO;
            out_reg  <= 1'b0;
            pend_reg <= 2'h0;
            irq_o    <= '0;
        end
        else
        begin
            if (ctrl_we_i)
                ctrl_reg <= ctrl_next;
            pre_reg  <= pre_reg + 10'h001;
            cnt_reg  <= cnt_next;
            ref_reg  <= ref_next;
            out_reg  <= out_next;
            pend_reg <= pend_next;
            irq_o    <= '{valid: req_next, vector: vec_next};
        end
    end
    always_comb
    begin
        timer_control_reg_o     = ctrl_reg;
        reference_data_reg_o    = ref_reg;
        counter_o               = cnt_reg;
        pwm_output_pin_o        = out_reg;
        interrupt_pending_reg_o = pend_reg;
        request_level_zero_o    = irq_o.valid;
    end
    // ==========================================================
    // checks
    sequence s_intv_match;
        match;
    endsequence
    sequence s_match_done;
        cnt_reg == IPCT_CNT_ZERO && out_reg != $past(out_reg);
    endsequence
    a_match_clears: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        match |=> cnt_reg == IPCT_CNT_ZERO)
        else $error("match did not clear");
    a_match_toggle: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        match |=> out_reg != $past(out_reg))
        else $error("no toggle on match");
    a_match_steps: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        s_intv_match |=> s_match_done)
        else $error("match steps wrong");
    a_pwm_wrap: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        ovf && !clr_req |=> cnt_reg == IPCT_CNT_ZERO)
        else $error("no wrap");
    a_pwm_no_clear: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        tick && is_pwm && !clr_req && cnt_reg == ref_reg
        |=> cnt_reg == $past(cnt_reg) + 8'h01)
        else $error("pwm match cleared counter");
    a_pwm_level: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        $past(is_pwm) && is_pwm |-> out_reg == (ref_reg > cnt_reg))
        else $error("pwm level wrong");
    a_cap_load: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        capture |=> ref_reg == $past(cnt_reg))
        else $error("capture lost");
    a_clr_self: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        ctrl_we_i |=> !ctrl_reg[IPCT_CLR_BIT])
        else $error("clear bit stuck");
    a_clr_cnt: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        clr_req |=> cnt_reg == IPCT_CNT_ZERO)
        else $error("clear did not zero counter");
    a_tick_step: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        tick && !clr_req && !match |=> cnt_reg == $past(cnt_reg) + 8'h01)
        else $error("counter step wrong");
    a_stop_hold: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        clk_sel == IPCT_CS_STOP && !ctrl_we_i && !match |=> $stable(cnt_reg))
        else $error("stopped counter moved");
    a_ovf_pend: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        set_ovf |=> pend_reg[IPCT_OVF_PND] && irq_o.valid)
        else $error("overflow not pending");
    a_ovf_ack: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        ack_ovf && !set_ovf |=> !pend_reg[IPCT_OVF_PND])
        else $error("overflow service did not clear");
    a_ovie_off: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        ovf && !ctrl_reg[IPCT_OVIE_BIT] && !pend_reg[IPCT_OVF_PND] |=> !pend_reg[IPCT_OVF_PND])
        else $error("disabled overflow pended");
    a_mc_pend: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        match && ctrl_reg[IPCT_MCIE_BIT] |=> pend_reg[IPCT_MC_PND] && irq_o.valid)
        else $error("match not pending");
    a_cap_pend: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        capture && ctrl_reg[IPCT_MCIE_BIT] |=> pend_reg[IPCT_MC_PND] && irq_o.valid)
        else $error("capture not pending");
    a_mc_ack: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        ack_mc && !set_mc |=> !pend_reg[IPCT_MC_PND])
        else $error("masked service did not clear");
    a_mc_hold: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        irq_ack_i && !interrupt_mask_reg_i && pend_reg[IPCT_MC_PND] && !pend_we_i
        |=> pend_reg[IPCT_MC_PND])
        else $error("unmasked service cleared match pending");
    a_vec_pick: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (|pend_reg) |-> irq_o.valid &&
        irq_o.vector == (pend_reg[IPCT_OVF_PND] ? IPCT_VEC_OVF : IPCT_VEC_MC))
        else $error("request or vector wrong");
    // ==========================================================
    // period helper: ticks since the last wrap, trusted only after one wrap
    logic [7:0] wrap_ticks_reg;
    logic       wrap_seen_reg;
    always_ff @(posedge sys_clk_i)
    begin
        if (sys_rst_i || !is_pwm || clr_req)
        begin
            wrap_ticks_reg <= IPCT_CNT_ZERO;
            wrap_seen_reg  <= 1'b0;
        end
        else if (ovf)
        begin
            wrap_ticks_reg <= IPCT_CNT_ZERO;
            wrap_seen_reg  <= 1'b1;
        end
        else if (tick)
            wrap_ticks_reg <= wrap_ticks_reg + 8'h01;
    end
    a_pwm_period: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        ovf && wrap_seen_reg |-> wrap_ticks_reg == IPCT_CNT_MAX)
        else $error("pwm period not 256 ticks");
endmodule
`default_nettype wire

// *** ipct_timer_tb.sv ***
`default_nettype none
module interval_pwm_capture_timer_tb_top
    import ipct_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // stimulus and observed signals
    logic       clk = 1'b0, rst = 1'b1, cwe = 1'b0, rwe = 1'b0, pwe = 1'b0;
    logic       ack = 1'b0, mask = 1'b0, ext = 1'b0, cap = 1'b0, pwm, rq;
    logic [7:0] cwd = 8'h00, rwd = 8'h00, p1 = 8'h00, avec = 8'h00;
    logic [7:0] ctl, rdat, cnt, c0;
    logic [1:0] pwd = 2'h3, pnd;
    ipct_irq_t  irq;
    int         miscompares = 0, comparisons = 0, cyc = 0, n, i;
    int         dv[5] = '{1024, 256, 64, 8, 1};
    logic [7:0] pv[3] = '{8'h00, 8'h80, 8'hFF};
    ipct_timer dut_u (.sys_clk_i(clk), .sys_rst_i(rst), .ctrl_we_i(cwe), .ctrl_wdata_i(cwd),
        .ref_we_i(rwe), .ref_wdata_i(rwd), .port_one_control_low_i(p1),
        .interrupt_mask_reg_i(mask), .pend_we_i(pwe), .pend_wdata_i(pwd), .irq_ack_i(ack),
        .irq_ack_vector_i(avec), .external_clock_pin_i(ext), .capture_input_pin_i(cap),
        .pwm_output_pin_o(pwm), .timer_control_reg_o(ctl), .reference_data_reg_o(rdat),
        .counter_o(cnt), .interrupt_pending_reg_o(pnd), .request_level_zero_o(rq), .irq_o(irq));
    initial forever #2.5 clk = ~clk;
    // ==========================================================
    // access tasks
    task automatic summarize();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc++;
        // whole run needs about 7700 cycles
        if (cyc == 30000)
        begin
            miscompares++;
            summarize();
        end
    end
    task automatic chk(input logic [8:0] s, input logic [8:0] e);
        comparisons++;
        if (s !== e)
        begin
            miscompares++;
            $display("Error at %0t: seen %0h expected %0h", $time, s, e);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(negedge clk);
    endtask
    // kind 0 control, 1 reference, 2 pending, 3 service acknowledge
    task automatic wr(input int k, input logic [7:0] v);
        @(negedge clk);
        case (k)
            0: begin cwe = 1'b1; cwd = v; end
            1: begin rwe = 1'b1; rwd = v; end
            2: begin pwe = 1'b1; pwd = v[1:0]; end
            default: begin ack = 1'b1; avec = v; end
        endcase
        @(negedge clk);
        {cwe, rwe, pwe, ack} = 4'h0;
    endtask
    task automatic waitp(input int b);
        n = 0;
        while (pnd[b] !== 1'b1 && n < 2000)
        begin
            @(negedge clk);
            n++;
        end
        chk(pnd[b], 1'b1);
    endtask
    task automatic pin(input int k);
        repeat (k)
        begin
            ext = 1'b1;
            tick(4);
            ext = 1'b0;
            tick(4);
        end
    endtask
    // ==========================================================
    // main sequence
    initial
    begin
        tick(6);
        rst = 1'b0;
        tick(1);
        chk(ctl, 8'h00);
        chk({cnt, pnd[0]}, 9'h000);
        wr(1, 8'hFF);
        for (i = 0; i < 5; i++)
        begin
            wr(0, {i[2:0], 5'h04});
            chk(ctl, {i[2:0], 5'h00});
            c0 = cnt;
            tick(4 * dv[i]);
            chk(8'(cnt - c0), 8'h04);
        end
        wr(0, 8'hE0);
        c0 = cnt;
        tick(50);
        chk(cnt, c0);
        wr(1, 8'h05);
        wr(0, 8'h86);
        waitp(1);
        chk({cnt, pwm}, 9'h001);
        chk(irq, {1'b1, 8'hCE});
        // mask bit clear: a service acknowledge must leave the match pending
        wr(3, 8'hCE);
        chk(pnd[1], 1'b1);
        wr(2, 8'h01);
        chk({pnd[1], rq}, 2'h0);
        waitp(1);
        chk(pwm, 1'b0);
        mask = 1'b1;
        wr(3, 8'hCE);
        chk({pnd[1], rq}, 2'h0);
        p1 = 8'h10;
        wr(0, 8'h8D);
        waitp(0);
        chk(irq, {1'b1, 8'hD0});
        chk({cnt, pnd[1]}, 9'h000);
        wr(3, 8'hD0);
        chk(pnd[0], 1'b0);
        waitp(0);
        wr(2, 8'h02);
        chk(pnd[0], 1'b0);
        p1 = 8'h00;
        wr(0, 8'hCE);
        pin(3);
        chk(cnt, 8'h03);
        cap = 1'b1;
        tick(6);
        chk({rdat, pnd[1]}, 9'h007);
        wr(2, 8'h01);
        cap = 1'b0;
        tick(6);
        chk(pnd[1], 1'b0);
        wr(0, 8'hB2);
        pin(2);
        cap = 1'b1;
        tick(6);
        chk(pnd[1], 1'b0);
        cap = 1'b0;
        tick(6);
        chk({rdat, pnd[1]}, 9'h00B);
        wr(2, 8'h01);
        p1 = 8'h10;
        pin(0);
        cap = 1'b1;
        tick(6);
        cap = 1'b0;
        tick(6);
        chk(pnd[1], 1'b0);
        for (i = 0; i < 3; i++)
        begin
            wr(1, pv[i]);
            wr(0, 8'h9C);
            tick(3);
            c0 = cnt;
            n = 0;
            repeat (512)
            begin
                @(negedge clk);
                n += int'(pwm === 1'b1);
            end
            chk(n[8:0], {pv[i], 1'b0});
            chk(cnt, c0);
        end
        summarize();
    end
endmodule
`default_nettype wire
